// ### logic/fp_panel_timing.sv
// panel timing, line pulse, frame marker and blank-time video shaping
`timescale 1ns/100ps

module fp_panel_timing #(
  parameter int HCOUNT_W = 9
) (
  input  wire logic       CLK_I,
  input  wire logic       SYS_RST_I,
  input  wire logic       REG_WR_I,
  input  wire logic       REG_RD_I,
  input  wire logic [7:0] REG_INDEX_I,
  input  wire logic [7:0] REG_WDATA_I,
  output logic      [7:0] REG_RDATA_O,
  input  wire logic       BORDER_WR_I,
  input  wire logic [7:0] BORDER_WDATA_I,
  input  wire logic       WP_GROUP1_I,
  input  wire logic       WP_BORDER_I,
  input  wire logic [1:0] MISC_SWITCH_SEL_I,
  output logic            SWITCH_SENSE_O,
  input  wire logic       CHAR_TICK_I,
  input  wire logic       DOT_TICK_I,
  input  wire logic       VSYNC_I,
  input  wire logic       VBLANK_I,
  input  wire logic       H_COMPRESS_I,
  input  wire logic       DUAL_PANEL_I,
  input  wire logic       SCREEN_OFF_I,
  input  wire logic       ADAPTER_EMU_I,
  input  wire logic       MODE_VIDEO_EN_I,
  input  wire logic       MODE_256_I,
  input  wire logic [2:0] PIXEL_PAN_I,
  input  wire logic [7:0] PIXEL_I,
  output logic      [7:0] VIDEO_O,
  output logic            HSYNC_O,
  output logic            FRAME_MARKER_O,
  output logic            LINE_PULSE_O,
  output logic            SHIFT_TICK_O,
  output logic            PANEL_BLANK_O,
  output logic      [7:0] PANEL_SIZE_O,
  output logic      [8:0] ROW_OFFSET_O,
  output logic      [4:0] TALL_ROW_LINES_O,
  output logic            VIDEO_PATH8_O,
  output logic      [2:0] PAN_SEL_O,
  output logic      [1:0] TALL_PLANE_O,
  output logic      [1:0] GRAY_MODE_O,
  output logic            DITHER_ON_O
);

  // ==========================================================================
  // elaboration checks
  if (HCOUNT_W < 9) begin : g_bad_width
    $error("HCOUNT_W must cover total plus five");
  end

  fp_timing_pkg::state_t st_q;
  fp_timing_pkg::state_t st_d;

  logic       blanked;
  logic       hblank_now;
  logic       blank_end;
  logic       line_end;
  logic       sync_start_hit;
  logic       sync_end_hit;
  logic       vsync_rise;
  logic [8:0] total_end;
  logic [8:0] lp_delay_val;
  logic [2:0] shift_last;

  // ==========================================================================
  // timing events
  assign total_end  = {1'b0, st_q.regs.total} + fp_timing_pkg::TOTAL_ADJUST;
  assign line_end   = CHAR_TICK_I && (st_q.hcount == total_end);
  // display end is only compared, so characters past it are blank time
  assign hblank_now = (st_q.hcount > {1'b0, st_q.regs.disp_end});
  assign blank_end  = st_q.blank_prev && !(hblank_now || VBLANK_I);
  assign sync_start_hit = CHAR_TICK_I &&
                          (st_q.hcount[7:0] == st_q.regs.sync_start);
  assign sync_end_hit   = CHAR_TICK_I &&
                          (st_q.hcount[4:0] == st_q.regs.sync_end[4:0]);
  assign vsync_rise   = VSYNC_I && !st_q.vsync_prev;
  assign lp_delay_val = {st_q.regs.lp_width[fp_timing_pkg::LP_DLY_MSB_BIT],
                         st_q.regs.lp_delay};
  assign blanked      = SCREEN_OFF_I ||
                        (ADAPTER_EMU_I && !MODE_VIDEO_EN_I);
  // divide by 1, 2, 4 or 8 dot ticks
  assign shift_last   = 3'((4'h1 << st_q.regs.panel_format[5:4]) - 4'h1);

  // ==========================================================================
  // next state
  always_comb begin
    st_d = st_q;
    st_d.vsync_prev = VSYNC_I;
    st_d.blank_prev = hblank_now || VBLANK_I;
    st_d.shift_tick = 1'b0;

    // register writes
    if (REG_WR_I) begin
      case (REG_INDEX_I)
        fp_timing_pkg::IDX_HORIZ_DISPLAY_END: begin
          st_d.regs.disp_end = REG_WDATA_I;
        end
        fp_timing_pkg::IDX_HORIZ_SYNC_START: begin
          st_d.regs.sync_start = REG_WDATA_I;
        end
        fp_timing_pkg::IDX_HORIZ_SYNC_END: begin
          st_d.regs.sync_end = REG_WDATA_I & fp_timing_pkg::SYNC_END_MASK;
        end
        fp_timing_pkg::IDX_HORIZ_TOTAL: begin
          st_d.regs.total = REG_WDATA_I;
        end
        fp_timing_pkg::IDX_HORIZ_SIZE: begin
          st_d.regs.panel_size = REG_WDATA_I;
        end
        fp_timing_pkg::IDX_BLANK_END_SKEW: begin
          st_d.regs.skew = REG_WDATA_I & fp_timing_pkg::SKEW_MASK;
        end
        fp_timing_pkg::IDX_ALT_ROW_OFFSET: begin
          st_d.regs.row_offset = REG_WDATA_I;
        end
        fp_timing_pkg::IDX_VIRTUAL_SWITCH: begin
          st_d.regs.vswitch = REG_WDATA_I & fp_timing_pkg::SWITCH_MASK;
        end
        fp_timing_pkg::IDX_ALT_MAX_SCANLINE: begin
          st_d.regs.max_scan = REG_WDATA_I & fp_timing_pkg::SCANLINE_MASK;
        end
        fp_timing_pkg::IDX_VIDEO_PATH_CTRL: begin
          st_d.regs.path_ctrl = REG_WDATA_I;
        end
        fp_timing_pkg::IDX_DEFAULT_VIDEO: begin
          st_d.regs.default_video = REG_WDATA_I;
        end
        fp_timing_pkg::IDX_FRAME_MARKER_DLY: begin
          st_d.regs.fm_delay = REG_WDATA_I;
        end
        fp_timing_pkg::IDX_LINE_PULSE_DLY: begin
          st_d.regs.lp_delay = REG_WDATA_I;
        end
        fp_timing_pkg::IDX_LINE_PULSE_WIDTH: begin
          st_d.regs.lp_width = REG_WDATA_I & fp_timing_pkg::WIDTH_MASK;
        end
        fp_timing_pkg::IDX_SCRATCH_FLAGS: begin
          st_d.regs.flags = REG_WDATA_I;
        end
        fp_timing_pkg::IDX_PANEL_FORMAT: begin
          st_d.regs.panel_format = REG_WDATA_I;
        end
        default: begin
        end
      endcase
    end

    // border color, guarded by two protect bits
    if (BORDER_WR_I && !WP_GROUP1_I && !WP_BORDER_I) begin
      st_d.border = BORDER_WDATA_I;
    end

    // register reads, reserved and sense bits return zero
    if (REG_RD_I) begin
      case (REG_INDEX_I)
        fp_timing_pkg::IDX_HORIZ_DISPLAY_END: st_d.rdata = st_q.regs.disp_end;
        fp_timing_pkg::IDX_HORIZ_SYNC_START: st_d.rdata = st_q.regs.sync_start;
        fp_timing_pkg::IDX_HORIZ_SYNC_END: st_d.rdata = st_q.regs.sync_end;
        fp_timing_pkg::IDX_HORIZ_TOTAL: st_d.rdata = st_q.regs.total;
        fp_timing_pkg::IDX_HORIZ_SIZE: st_d.rdata = st_q.regs.panel_size;
        fp_timing_pkg::IDX_BLANK_END_SKEW: st_d.rdata = st_q.regs.skew;
        fp_timing_pkg::IDX_ALT_ROW_OFFSET: st_d.rdata = st_q.regs.row_offset;
        fp_timing_pkg::IDX_VIRTUAL_SWITCH: begin
          st_d.rdata = {4'h0, st_q.regs.vswitch[3:0]};
        end
        fp_timing_pkg::IDX_ALT_MAX_SCANLINE: st_d.rdata = st_q.regs.max_scan;
        fp_timing_pkg::IDX_VIDEO_PATH_CTRL: st_d.rdata = st_q.regs.path_ctrl;
        fp_timing_pkg::IDX_DEFAULT_VIDEO: begin
          st_d.rdata = st_q.regs.default_video;
        end
        fp_timing_pkg::IDX_FRAME_MARKER_DLY: st_d.rdata = st_q.regs.fm_delay;
        fp_timing_pkg::IDX_LINE_PULSE_DLY: st_d.rdata = st_q.regs.lp_delay;
        fp_timing_pkg::IDX_LINE_PULSE_WIDTH: st_d.rdata = st_q.regs.lp_width;
        fp_timing_pkg::IDX_SCRATCH_FLAGS: st_d.rdata = st_q.regs.flags;
        fp_timing_pkg::IDX_PANEL_FORMAT: st_d.rdata = st_q.regs.panel_format;
        default: st_d.rdata = 8'h00;
      endcase
    end

    // character counter
    if (line_end) begin
      st_d.hcount = 9'h000;
    end else if (CHAR_TICK_I) begin
      st_d.hcount = st_q.hcount + 9'h001;
    end

    // panel sync: end wins so a zero width never sticks high
    if (sync_end_hit) begin
      st_d.hsync = 1'b0;
    end else if (sync_start_hit) begin
      st_d.hsync = 1'b1;
    end

    // frame marker width counted in panel syncs, so a delayed start spans whole lines
    if (st_q.frame_marker && sync_start_hit) begin
      if (st_q.fm_lines == 2'h1) begin
        st_d.frame_marker = 1'b0;
      end
      st_d.fm_lines = st_q.fm_lines - 2'h1;
    end

    // frame marker start
    if (vsync_rise) begin
      if (st_q.regs.lp_width[fp_timing_pkg::FM_DLY_OFF_BIT] ||
          (st_q.regs.fm_delay == 8'h00)) begin
        st_d.frame_marker = 1'b1;
        st_d.fm_armed     = 1'b0;
        st_d.fm_lines     = DUAL_PANEL_I ? fp_timing_pkg::WIDTH_TWO_LINES
                                         : fp_timing_pkg::WIDTH_ONE_LINE;
      end else begin
        st_d.fm_armed = 1'b1;
        st_d.fm_count = st_q.regs.fm_delay;
      end
    end else if (st_q.fm_armed && sync_start_hit) begin
      if (st_q.fm_count == 8'h01) begin
        st_d.fm_armed     = 1'b0;
        st_d.frame_marker = 1'b1;
        st_d.fm_lines     = DUAL_PANEL_I ? fp_timing_pkg::WIDTH_TWO_LINES
                                         : fp_timing_pkg::WIDTH_ONE_LINE;
      end
      st_d.fm_count = st_q.fm_count - 8'h01;
    end

    // line pulse width, then start; a new start restarts the width
    if (st_q.line_pulse && CHAR_TICK_I) begin
      if (st_q.lp_wcount == 4'h0) begin
        st_d.line_pulse = 1'b0;
      end else begin
        st_d.lp_wcount = st_q.lp_wcount - 4'h1;
      end
    end
    if (blank_end) begin
      if (st_q.regs.lp_width[fp_timing_pkg::LP_DLY_OFF_BIT] || H_COMPRESS_I) begin
        st_d.line_pulse = 1'b1;
        st_d.lp_armed   = 1'b0;
        st_d.lp_wcount  = st_q.regs.lp_width[3:0];
      end else begin
        st_d.lp_armed = 1'b1;
        st_d.lp_count = lp_delay_val;
      end
    end else if (st_q.lp_armed && CHAR_TICK_I) begin
      if (st_q.lp_count == 9'h000) begin
        st_d.lp_armed   = 1'b0;
        st_d.line_pulse = 1'b1;
        st_d.lp_wcount  = st_q.regs.lp_width[3:0];
      end else begin
        st_d.lp_count = st_q.lp_count - 9'h001;
      end
    end

    // shift clock divider
    if (DOT_TICK_I) begin
      if (st_q.shift_count >= shift_last) begin
        st_d.shift_count = 3'h0;
        st_d.shift_tick  = 1'b1;
      end else begin
        st_d.shift_count = st_q.shift_count + 3'h1;
      end
    end

    // video forcing sits ahead of palette and gray logic
    if (blanked) begin
      st_d.video = st_q.regs.default_video;
    end else if (hblank_now || VBLANK_I) begin
      st_d.video = st_q.regs.path_ctrl[fp_timing_pkg::SHUT_OFF_BIT]
                 ? st_q.regs.default_video : st_q.border;
    end else begin
      st_d.video = PIXEL_I;
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // outputs
  assign REG_RDATA_O    = st_q.rdata;
  assign VIDEO_O        = st_q.video;
  assign HSYNC_O        = st_q.hsync;
  assign FRAME_MARKER_O = st_q.frame_marker;
  assign LINE_PULSE_O   = st_q.line_pulse;
  assign SHIFT_TICK_O   = st_q.shift_tick;
  assign PANEL_BLANK_O  = st_q.blank_prev;
  assign PANEL_SIZE_O   = st_q.regs.panel_size;
  assign ROW_OFFSET_O   = {1'b0, st_q.regs.row_offset} + 9'h001;
  assign TALL_ROW_LINES_O = st_q.regs.max_scan[4:0];
  assign SWITCH_SENSE_O = st_q.regs.vswitch[fp_timing_pkg::SENSE_BIT] &&
                          st_q.regs.vswitch[3 - MISC_SWITCH_SEL_I];
  assign VIDEO_PATH8_O  = st_q.regs.path_ctrl[fp_timing_pkg::PATH8_BIT];
  // on the 8-bit path, bit 0 of panning only counts with the three-bit option; otherwise it always counts
  assign PAN_SEL_O = !VIDEO_PATH8_O ? PIXEL_PAN_I
                   : st_q.regs.path_ctrl[fp_timing_pkg::PAN3_BIT]
                   ? PIXEL_PAN_I : {PIXEL_PAN_I[2:1], 1'b0};
  assign TALL_PLANE_O = st_q.regs.path_ctrl[fp_timing_pkg::TALL_PLANE_BIT]
                      ? fp_timing_pkg::PLANE_TWO
                      : fp_timing_pkg::PLANE_THREE;
  assign GRAY_MODE_O =
    st_q.regs.panel_format[fp_timing_pkg::GRAY_OVERRIDE_BIT]
    ? fp_timing_pkg::GRAY_EXTENDED : st_q.regs.panel_format[1:0];
  assign DITHER_ON_O =
    (st_q.regs.panel_format[3:2] == fp_timing_pkg::DITHER_ALL) ||
    ((st_q.regs.panel_format[3:2] == fp_timing_pkg::DITHER_256_ONLY) &&
     MODE_256_I);

  // ==========================================================================
  // checks
  property p_border_guard;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      BORDER_WR_I && (WP_GROUP1_I || WP_BORDER_I) |=> $stable(st_q.border);
  endproperty
  a_border_guard: assert property (p_border_guard)
    else $error("border color changed while protected");

  property p_sync_start;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      sync_start_hit && !sync_end_hit |=> HSYNC_O;
  endproperty
  a_sync_start: assert property (p_sync_start)
    else $error("panel sync did not start");

  property p_sync_end;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      sync_end_hit |=> !HSYNC_O;
  endproperty
  a_sync_end: assert property (p_sync_end)
    else $error("panel sync did not end");

  property p_counter_wrap;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      line_end |=> st_q.hcount == 9'h000;
  endproperty
  a_counter_wrap: assert property (p_counter_wrap)
    else $error("character counter missed its wrap");

  property p_border_video;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      !blanked && (hblank_now || VBLANK_I) &&
      !st_q.regs.path_ctrl[fp_timing_pkg::SHUT_OFF_BIT]
      |=> VIDEO_O == $past(st_q.border);
  endproperty
  a_border_video: assert property (p_border_video)
    else $error("blank time video is not the border color");

  property p_blanked_video;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      blanked |=> VIDEO_O == $past(st_q.regs.default_video);
  endproperty
  a_blanked_video: assert property (p_blanked_video)
    else $error("blanked screen is not default video");

  property p_lp_direct;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      blank_end && (st_q.regs.lp_width[fp_timing_pkg::LP_DLY_OFF_BIT] ||
                    H_COMPRESS_I)
      |=> LINE_PULSE_O &&
          st_q.lp_wcount == $past(st_q.regs.lp_width[3:0]);
  endproperty
  a_lp_direct: assert property (p_lp_direct)
    else $error("line pulse not at blank end");

  property p_fm_direct;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      vsync_rise && st_q.regs.lp_width[fp_timing_pkg::FM_DLY_OFF_BIT]
      |=> FRAME_MARKER_O;
  endproperty
  a_fm_direct: assert property (p_fm_direct)
    else $error("frame marker not at internal vsync");

  property p_sense_read;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      REG_RD_I && (REG_INDEX_I == fp_timing_pkg::IDX_VIRTUAL_SWITCH)
      |=> REG_RDATA_O[7:4] == 4'h0;
  endproperty
  a_sense_read: assert property (p_sense_read)
    else $error("sense bit did not read zero");

endmodule // fp_panel_timing

// ### logic/fp_timing_pkg.sv
// package: register indices, field positions, reset values and state for the panel timing block
package fp_timing_pkg;

  // ==========================================================================
  // register indices on the extension index port
  localparam logic [7:0] IDX_HORIZ_DISPLAY_END = 8'h18;
  localparam logic [7:0] IDX_HORIZ_SYNC_START  = 8'h19;
  localparam logic [7:0] IDX_HORIZ_SYNC_END    = 8'h1a;
  localparam logic [7:0] IDX_HORIZ_TOTAL       = 8'h1b;
  localparam logic [7:0] IDX_HORIZ_SIZE        = 8'h1c;
  localparam logic [7:0] IDX_BLANK_END_SKEW    = 8'h1d;
  localparam logic [7:0] IDX_ALT_ROW_OFFSET    = 8'h1e;
  localparam logic [7:0] IDX_VIRTUAL_SWITCH    = 8'h1f;
  localparam logic [7:0] IDX_ALT_MAX_SCANLINE  = 8'h24;
  localparam logic [7:0] IDX_VIDEO_PATH_CTRL   = 8'h28;
  localparam logic [7:0] IDX_DEFAULT_VIDEO     = 8'h2b;
  localparam logic [7:0] IDX_FRAME_MARKER_DLY  = 8'h2c;
  localparam logic [7:0] IDX_LINE_PULSE_DLY    = 8'h2d;
  localparam logic [7:0] IDX_LINE_PULSE_WIDTH  = 8'h2f;
  localparam logic [7:0] IDX_SCRATCH_FLAGS     = 8'h44;
  localparam logic [7:0] IDX_PANEL_FORMAT      = 8'h50;

  // ==========================================================================
  // field positions and masks
  localparam int          SENSE_BIT         = 7;
  localparam int          SHUT_OFF_BIT      = 2;
  localparam int          PATH8_BIT         = 4;
  localparam int          PAN3_BIT          = 6;
  localparam int          TALL_PLANE_BIT    = 7;
  localparam int          LP_DLY_MSB_BIT    = 5;
  localparam int          LP_DLY_OFF_BIT    = 6;
  localparam int          FM_DLY_OFF_BIT    = 7;
  localparam int          GRAY_OVERRIDE_BIT = 6;
  localparam logic [7:0]  SYNC_END_MASK     = 8'h1f;
  localparam logic [7:0]  SWITCH_MASK       = 8'h8f;
  localparam logic [7:0]  SCANLINE_MASK     = 8'h1f;
  localparam logic [7:0]  SKEW_MASK         = 8'h60;
  localparam logic [7:0]  WIDTH_MASK        = 8'hef;
  localparam logic [8:0]  TOTAL_ADJUST      = 9'h004;
  localparam logic [7:0]  REG_RESET         = 8'h00;

  // ==========================================================================
  // encodings
  localparam logic [1:0]  DITHER_OFF        = 2'h0;
  localparam logic [1:0]  DITHER_256_ONLY   = 2'h1;
  localparam logic [1:0]  DITHER_ALL        = 2'h2;
  localparam logic [1:0]  PLANE_TWO         = 2'h2;
  localparam logic [1:0]  PLANE_THREE       = 2'h3;
  localparam logic [1:0]  GRAY_EXTENDED     = 2'h3;
  localparam logic [1:0]  WIDTH_ONE_LINE    = 2'h1;
  localparam logic [1:0]  WIDTH_TWO_LINES   = 2'h2;

  // ==========================================================================
  // programmed registers
  typedef struct packed {
    logic [7:0] disp_end;
    logic [7:0] sync_start;
    logic [7:0] sync_end;
    logic [7:0] total;
    logic [7:0] panel_size;
    logic [7:0] skew;
    logic [7:0] row_offset;
    logic [7:0] vswitch;
    logic [7:0] max_scan;
    logic [7:0] path_ctrl;
    logic [7:0] default_video;
    logic [7:0] fm_delay;
    logic [7:0] lp_delay;
    logic [7:0] lp_width;
    logic [7:0] flags;
    logic [7:0] panel_format;
  } regs_t;

  // whole state of the block
  typedef struct packed {
    regs_t      regs;
    logic [7:0] border;
    logic [7:0] rdata;
    logic [8:0] hcount;
    logic       hsync;
    logic       blank_prev;
    logic       vsync_prev;
    logic       fm_armed;
    logic [7:0] fm_count;
    logic       frame_marker;
    logic [1:0] fm_lines;
    logic       lp_armed;
    logic [8:0] lp_count;
    logic       line_pulse;
    logic [3:0] lp_wcount;
    logic [2:0] shift_count;
    logic       shift_tick;
    logic [7:0] video;
  } state_t;

endpackage : fp_timing_pkg

// ### testbench/fp_panel_model.sv
// panel side model: measures pulse runs and counts line syncs at the pins
`timescale 1ns/100ps
// ============================================================
// pulse run meter
module fp_panel_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] pins_i,
  output int              len_o [4],
  output int              hs_rise_o
);
  int   run [4];
  logic hs_prev;
  // a run is reported only once it ends, so a stuck pin never looks valid
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        run[i] <= 0;
        len_o[i] <= 0;
      end
      hs_prev <= 1'b0;
      hs_rise_o <= 0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (pins_i[i] === 1'b1) begin
          run[i] <= run[i] + 1;
        end else if (run[i] != 0) begin
          len_o[i] <= run[i];
          run[i] <= 0;
        end
      end
      hs_prev <= (pins_i[2] === 1'b1);
      if (pins_i[2] === 1'b1 && !hs_prev) begin
        hs_rise_o <= hs_rise_o + 1;
      end
    end
  end
endmodule // fp_panel_model

// ### testbench/test_flat_panel_timing_control.sv
// self-checking bench of the panel timing block
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t: %h expected %h", $time, a, b); end end
`define WAIT(c) begin k = 0; while (!(c) && k < 2000) begin step(1); k++; \
  end if (k >= 2000) begin n_mismatch++; finish_test(); end end
// ============================================================
// top
module test_flat_panel_timing_control;
  logic CLK_I, SYS_RST_I, REG_WR_I, REG_RD_I, BORDER_WR_I, WP_GROUP1_I;
  logic WP_BORDER_I, CHAR_TICK_I, DOT_TICK_I, VSYNC_I, VBLANK_I;
  logic H_COMPRESS_I, DUAL_PANEL_I, SCREEN_OFF_I, ADAPTER_EMU_I;
  logic MODE_VIDEO_EN_I, MODE_256_I, SWITCH_SENSE_O, HSYNC_O, SHIFT_TICK_O;
  logic FRAME_MARKER_O, LINE_PULSE_O, PANEL_BLANK_O, VIDEO_PATH8_O;
  logic DITHER_ON_O;
  logic [7:0] REG_INDEX_I, REG_WDATA_I, BORDER_WDATA_I, PIXEL_I;
  logic [7:0] REG_RDATA_O, VIDEO_O, PANEL_SIZE_O;
  logic [1:0] MISC_SWITCH_SEL_I, TALL_PLANE_O, GRAY_MODE_O;
  logic [2:0] PIXEL_PAN_I, PAN_SEL_O;
  logic [8:0] ROW_OFFSET_O;
  logic [4:0] TALL_ROW_LINES_O;
  int         pm_len [4];
  int         pm_hs, n_mismatch, n_compared, k;
  localparam logic [7:0] IDX [17] = '{8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c,
    8'h1d, 8'h1e, 8'h1f, 8'h24, 8'h28, 8'h2b, 8'h2c, 8'h2d, 8'h2f, 8'h44,
    8'h50, 8'h20};

  fp_panel_timing dut (.CLK_I, .SYS_RST_I, .REG_WR_I, .REG_RD_I,
    .REG_INDEX_I, .REG_WDATA_I, .REG_RDATA_O, .BORDER_WR_I, .BORDER_WDATA_I,
    .WP_GROUP1_I, .WP_BORDER_I, .MISC_SWITCH_SEL_I, .SWITCH_SENSE_O,
    .CHAR_TICK_I, .DOT_TICK_I, .VSYNC_I, .VBLANK_I, .H_COMPRESS_I,
    .DUAL_PANEL_I, .SCREEN_OFF_I, .ADAPTER_EMU_I, .MODE_VIDEO_EN_I,
    .MODE_256_I, .PIXEL_PAN_I, .PIXEL_I, .VIDEO_O, .HSYNC_O, .FRAME_MARKER_O,
    .LINE_PULSE_O, .SHIFT_TICK_O, .PANEL_BLANK_O, .PANEL_SIZE_O,
    .ROW_OFFSET_O, .TALL_ROW_LINES_O, .VIDEO_PATH8_O, .PAN_SEL_O,
    .TALL_PLANE_O, .GRAY_MODE_O, .DITHER_ON_O);
  fp_panel_model pm (.clk_i(CLK_I), .rst_i(SYS_RST_I), .len_o(pm_len),
    .pins_i({PANEL_BLANK_O, HSYNC_O, FRAME_MARKER_O, LINE_PULSE_O}),
    .hs_rise_o(pm_hs));

  initial begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end
  // ==========================================================
  // helpers
  task automatic step(input int n);
    repeat (n) @(posedge CLK_I);
    #1;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    {REG_WR_I, REG_INDEX_I, REG_WDATA_I} = {1'b1, i, d};
    step(1);
    REG_WR_I = 1'b0;
    // let an edge pass so a following strobe is a fresh pulse
    step(1);
  endtask
  task automatic rd(input logic [7:0] i, output logic [7:0] d);
    {REG_RD_I, REG_INDEX_I} = {1'b1, i};
    step(1);
    REG_RD_I = 1'b0;
    d = REG_RDATA_O;
    step(1);
  endtask
  function automatic logic [7:0] mask(input logic [7:0] i);
    case (i)
      8'h1a, 8'h24: mask = 8'h1f;
      8'h1f: mask = 8'h0f;
      8'h1d: mask = 8'h60;
      8'h2f: mask = 8'hef;
      8'h20: mask = 8'h00;
      default: mask = 8'hff;
    endcase
  endfunction
  // blank end to line pulse rise, in cycles
  task automatic meas_lp(output int r);
    `WAIT(PANEL_BLANK_O === 1'b1)
    `WAIT(PANEL_BLANK_O === 1'b0)
    `WAIT(LINE_PULSE_O === 1'b1)
    r = k;
  endtask
  task finish_test;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    int d0, d1, v, w, n;
    logic [7:0] b, x, e, s;
    {REG_WR_I, REG_RD_I, BORDER_WR_I, WP_GROUP1_I, WP_BORDER_I, CHAR_TICK_I,
     DOT_TICK_I, VSYNC_I, VBLANK_I, H_COMPRESS_I, DUAL_PANEL_I, SCREEN_OFF_I,
     MODE_256_I, REG_INDEX_I, REG_WDATA_I, BORDER_WDATA_I, PIXEL_I,
     MISC_SWITCH_SEL_I, PIXEL_PAN_I} = '0;
    {ADAPTER_EMU_I, MODE_VIDEO_EN_I, SYS_RST_I} = 3'h7;
    n_mismatch = 0;
    n_compared = 0;
    void'($urandom(32'hb4995028));
    step(5);
    SYS_RST_I = 1'b0;
    `CHK(TALL_PLANE_O, 2'h3)
    for (int i = 0; i < 17; i++) begin
      rd(IDX[i], x);
      `CHK(x, 8'h00)
      b = 8'($urandom);
      wr(IDX[i], b);
      rd(IDX[i], x);
      `CHK(x, b & mask(IDX[i]))
    end
    wr(8'h1e, b);
    wr(8'h24, b);
    wr(8'h1c, 8'h4f);
    step(2);
    `CHK(ROW_OFFSET_O, {1'b0, b} + 9'h001)
    `CHK(TALL_ROW_LINES_O, b[4:0])
    `CHK(PANEL_SIZE_O, 8'h4f)
    s = 8'($urandom);
    for (int i = 0; i < 8; i++) begin
      wr(8'h1f, {i[2], 3'h0, s[3:0]});
      MISC_SWITCH_SEL_I = i[1:0];
      step(1);
      `CHK(SWITCH_SENSE_O, i[2] & s[3 - i[1:0]])
    end
    for (int i = 0; i < 8; i++) begin
      PIXEL_PAN_I = 3'($urandom);
      wr(8'h28, {i[2], i[1], 1'b0, i[0], 4'h0});
      step(1);
      `CHK(VIDEO_PATH8_O, i[0])
      `CHK(PAN_SEL_O, (i[0] & !i[1]) ? {PIXEL_PAN_I[2:1], 1'b0}
        : PIXEL_PAN_I)
      `CHK(TALL_PLANE_O, i[2] ? 2'h2 : 2'h3)
    end
    for (int i = 0; i < 32; i++) begin
      MODE_256_I = 1'($urandom);
      wr(8'h50, {1'b0, i[4], 2'h0, i[3:0]});
      step(1);
      `CHK(GRAY_MODE_O, i[4] ? 2'h3 : i[1:0])
      `CHK(DITHER_ON_O,
        i[3:2] == 2'h2 || (i[3:2] == 2'h1 && MODE_256_I))
    end
    // refused border writes must leave the first accepted colour in place
    VBLANK_I = 1'b1;
    e = 8'h00;
    for (int p = 0; p < 4; p++) begin
      b = 8'($urandom);
      {WP_GROUP1_I, WP_BORDER_I, BORDER_WR_I, BORDER_WDATA_I} = {p[1:0], 1'b1, b};
      step(1);
      BORDER_WR_I = 1'b0;
      if (p == 0) e = b;
      wr(8'h28, 8'h00);
      step(2);
      `CHK(VIDEO_O, e)
    end
    s = 8'($urandom);
    wr(8'h2b, s);
    for (int c = 0; c < 8; c++) begin
      {SCREEN_OFF_I, MODE_VIDEO_EN_I} = {c[1], !c[2]};
      wr(8'h28, {5'h0, c[0], 2'h0});
      step(2);
      `CHK(VIDEO_O, (c[2:0] != 3'h0 && c[2:0] != 3'h0) && c != 0
        ? s : e)
    end
    DOT_TICK_I = 1'b1;
    for (int cd = 0; cd < 4; cd++) begin
      wr(8'h50, {2'h0, cd[1:0], 4'h0});
      step(16);
      n = 0;
      repeat (64) begin
        step(1);
        n += (SHIFT_TICK_O === 1'b1);
      end
      `CHK(n, 64 >> cd)
    end
    // line of 65 characters, blank from count 41 to 64
    {CHAR_TICK_I, VBLANK_I} = 2'h2;
    b = 8'd42 + 8'($urandom % 8);
    w = 1 + $urandom % 10;
    wr(8'h19, b);
    wr(8'h1a, (b + 8'(w)) & 8'h1f);
    wr(8'h1b, 8'd60);
    wr(8'h18, 8'd40);
    step(200);
    `CHK(pm_len[3], 24)
    `WAIT(HSYNC_O === 1'b0)
    `WAIT(HSYNC_O === 1'b1)
    `WAIT(HSYNC_O === 1'b0)
    d0 = k;
    `WAIT(HSYNC_O === 1'b1)
    `CHK(d0, w)
    `CHK(d0 + k, 65)
    w = $urandom % 16;
    wr(8'h2f, {4'h4, 4'(w)});
    step(140);
    meas_lp(d0);
    `CHK(d0, 0)
    v = $urandom % 31;
    wr(8'h2d, 8'(v));
    wr(8'h2f, {4'h0, 4'(w)});
    step(140);
    meas_lp(d1);
    `CHK(d1 - d0, v + 1)
    `CHK(pm_len[0], w + 1)
    // compression bypasses the programmed delay
    H_COMPRESS_I = 1'b1;
    step(140);
    meas_lp(d0);
    `CHK(d0, 0)
    H_COMPRESS_I = 1'b0;
    v = 1 + $urandom % 5;
    wr(8'h2c, 8'(v));
    for (int dp = 0; dp < 2; dp++) begin
      DUAL_PANEL_I = dp[0];
      `WAIT(HSYNC_O === 1'b0)
      `WAIT(HSYNC_O === 1'b1)
      step(1);
      d0 = pm_hs;
      VSYNC_I = 1'b1;
      `WAIT(FRAME_MARKER_O === 1'b1)
      step(1);
      `CHK(pm_hs - d0, v)
      VSYNC_I = 1'b0;
      `WAIT(FRAME_MARKER_O === 1'b0)
      step(1);
      `CHK(pm_len[1], 65 * (dp + 1))
    end
    wr(8'h2f, 8'h80);
    VSYNC_I = 1'b1;
    `WAIT(FRAME_MARKER_O === 1'b1)
    `CHK(k, 1)
    finish_test();
  end
endmodule // test_flat_panel_timing_control
